// ==== logic/wrc_top.sv ====
// wake-up, chip reset and code protection controller
//
// How it works
// (RULE_01) pin irq wakes deep modes if doubly enabled
// (RULE_02) peripheral irqs need controller and enable one
// (RULE_03) brownout wake needs irq enable, powered
// (RULE_04) brownout reset needs reset enable, powered
// (RULE_05) watchdog wake needs enable, feed, mode, oscillator
// (RULE_06) wake timer starts on count write
// (RULE_07) host clocks slave peripheral for wake
// (RULE_08) touch wake needs watchdog clock, irq
// (RULE_09) wake pin ends deep powerdown if enabled
// (RULE_10) reset pin wakes deep powerdown if enabled
// (RULE_11) timer wakes powerdown with oscillator kept
// (RULE_12) reset pin wakes sleeps if function enabled
// (RULE_13) boot on internal oscillator, others when stable
// (RULE_14) four sources reset chip, start oscillator
// (RULE_15) reset pin low 50 ns resets
// (RULE_16) fetch from address zero after reset
// (RULE_17) brownout raises irq, visible in status
// (RULE_18) four selectable brownout reset levels
// (RULE_19) protection levels restrict debug and programming
// (RULE_20) application programming always allowed
// (RULE_21) reset pin picks scan or debug
// (RULE_22) tester holds reset then drives low
// (RULE_23) enabled sources ORed into one wake
`timescale 1ns/100ps
`default_nettype none
module wrc_top #(
  parameter int NPIN  = 8,   // pin interrupt lines
  parameter int WKT_W = 32   // wake timer width
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  // register port
  input  wire logic [5:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  // pins and analog detectors
  input  wire logic             reset_pin_n,
  input  wire logic             wakeup_pin_n,
  input  wire logic             por_n,
  input  wire logic [3:0]       bod_below,
  // interrupt sources and controller enables
  input  wire logic [NPIN-1:0]  pin_irq,
  input  wire logic [NPIN-1:0]  pin_irq_ie,
  input  wire logic [4:0]       per_irq_ie,
  input  wire logic             other_irq,
  input  wire logic             wdt_irq,
  input  wire logic             wdt_rst,
  input  wire logic             wdt_fed,
  input  wire logic             spi_irq,
  input  wire logic             touch_irq,
  // clock source status, protection pattern
  input  wire logic             ext_clk_stable,
  input  wire logic [1:0]       prot_pattern,
  // results
  output logic                  wake_req,
  output logic [2:0]            power_mode,
  output logic                  chip_reset,
  output logic                  osc_start,
  output logic                  flash_init,
  output logic [31:0]           boot_addr,
  output logic                  bod_irq,
  output logic                  ext_clk_en,
  output logic                  ext_clk_sel,
  output logic                  bscan_sel,
  output logic                  dbg_en,
  output logic                  isp_en,
  output logic                  isp_sector0_ok,
  output logic                  isp_full_only,
  output logic                  iap_en
);

  // ----------------------------------------
  // state declarations
  // ----------------------------------------
  logic [NPIN-1:0]      sle0_q, sle0_d;     // pin wake enables
  logic [wrc_pkg::S1_W-1:0] sle1_q, sle1_d; // peripheral wake enables
  logic [3:0]           bodc_q, bodc_d;     // brownout control
  logic [1:0]           spc_q, spc_d;       // sleep power config
  logic [2:0]           wdm_q, wdm_d;       // watchdog mode bits
  logic [3:0]           dpd_q, dpd_d;       // deep powerdown control
  logic [3:0]           pfe_q, pfe_d;       // pin function enable
  logic [1:0]           wkc_q, wkc_d;       // timer / touch clock select
  logic [1:0]           clk_q, clk_d;       // clock source control
  logic [WKT_W-1:0]     wkn_q, wkn_d;       // wake timer count
  logic                 wkr_q, wkr_d;       // wake timer running
  logic                 wkt_to;             // timer time-out this cycle
  wrc_pkg::wrc_mode_type md_q, md_d;        // power mode
  wrc_pkg::wrc_rst_type  rs_q, rs_d;        // chip reset state
  logic [3:0]           hold_q, hold_d;     // reset hold count
  logic [2:0]           rpl_q, rpl_d;       // reset pin low count
  logic [1:0]           prot_q, prot_d;     // latched protection level
  logic                 strt_q, strt_d;     // oscillator / flash pulse
  logic [31:0]          rd_q, rd_d;         // read data
  logic                 wake_q, wake_d;     // registered wake
  logic                 bsc_q, dbg_q;       // scan select, debug enable
  logic                 bod_low;            // supply below chosen level
  logic                 deep;               // deep-sleep or power-down
  logic                 light;              // run or sleep
  logic                 pin_rst, bod_rst, wd_rst, any_rst;
  logic                 wake;               // combined wake request
  logic [wrc_pkg::S1_W-1:0] per_src;        // qualified peripheral irqs
  logic                 soft_rst;           // register reset

  assign soft_rst = reset | (rs_q == wrc_pkg::RS_HOLD);
  assign light    = (md_q == wrc_pkg::MD_RUN) | (md_q == wrc_pkg::MD_SLEEP);
  assign deep     = (md_q == wrc_pkg::MD_DSLEEP) | (md_q == wrc_pkg::MD_PDOWN);

  // ----------------------------------------
  // brownout detector
  // ----------------------------------------
  // (RULE_18) level select
  assign bod_low = bod_below[bodc_q[wrc_pkg::BC_LVL +: 2]];

  // ----------------------------------------
  // reset sources
  // ----------------------------------------
  always_comb
  begin
    // pin counted low for the least pulse width
    rpl_d = reset_pin_n ? 3'h0 : ((rpl_q == 3'h7) ? rpl_q : rpl_q + 3'h1);
    // (RULE_15) pulse width check
    pin_rst = !reset_pin_n && (rpl_q >= 3'(wrc_pkg::RST_PIN_CYC - 1));
    // (RULE_10) gated in deep powerdown
    if (md_q == wrc_pkg::MD_DPD)
      pin_rst = pin_rst & dpd_q[wrc_pkg::DC_RST];
    // (RULE_12) gated by pin function
    else
      pin_rst = pin_rst & pfe_q[wrc_pkg::PF_RST];
    // (RULE_04) brownout reset qualify
    bod_rst = bod_low & bodc_q[wrc_pkg::BC_RST] & (light | (deep & spc_q[wrc_pkg::SP_BOD]));
    // (RULE_05) watchdog reset qualify
    wd_rst  = wdt_rst & wdm_q[wrc_pkg::WM_EN] & wdm_q[wrc_pkg::WM_RST]
              & (light | (deep & spc_q[wrc_pkg::SP_WDO]));
    // (RULE_14) four reset sources
    any_rst = pin_rst | bod_rst | wd_rst | !por_n;
  end

  // ----------------------------------------
  // chip reset sequencer
  // ----------------------------------------
  always_comb
  begin
    rs_d   = rs_q;
    hold_d = hold_q;
    strt_d = 1'b0;
    prot_d = prot_q;
    case (rs_q)
      wrc_pkg::RS_RUN:
        begin
          // (RULE_14) start oscillator and flash
          if (any_rst)
          begin
            rs_d   = wrc_pkg::RS_HOLD;
            hold_d = 4'h0;
            strt_d = 1'b1;
          end
        end
      wrc_pkg::RS_HOLD:
        begin
          // hold restarts while any source persists
          if (any_rst)
            hold_d = 4'h0;
          else if (hold_q == 4'(wrc_pkg::RST_HOLD_CYC - 1))
          begin
            rs_d   = wrc_pkg::RS_RUN;
            prot_d = prot_pattern;  // latch pattern at release
          end
          else
            hold_d = hold_q + 4'h1;
        end
      default:
        rs_d = wrc_pkg::RS_HOLD;
    endcase
  end

  // reset sequencer registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rs_q   <= wrc_pkg::RS_HOLD;
      hold_q <= 4'h0;
      strt_q <= 1'b1;
      rpl_q  <= 3'h0;
      prot_q <= wrc_pkg::PL_THR;  // locked until first release
    end
    else
    begin
      rs_q   <= rs_d;
      hold_q <= hold_d;
      strt_q <= strt_d;
      rpl_q  <= rpl_d;
      prot_q <= prot_d;
    end
  end

  // ----------------------------------------
  // wake sources
  // ----------------------------------------
  always_comb
  begin
    // (RULE_03) brownout irq qualify
    per_src[wrc_pkg::S1_BOD] = bod_low & bodc_q[wrc_pkg::BC_INT] & spc_q[wrc_pkg::SP_BOD];
    // (RULE_05) watchdog irq qualify
    per_src[wrc_pkg::S1_WDT] = wdt_irq & wdm_q[wrc_pkg::WM_EN] & wdt_fed & wdm_q[wrc_pkg::WM_INT]
                               & spc_q[wrc_pkg::SP_WDO];
    per_src[wrc_pkg::S1_WKT] = wkt_to;
    // (RULE_07) host supplies slave clock
    per_src[wrc_pkg::S1_SPI] = spi_irq;
    // (RULE_08) touch on watchdog clock
    per_src[wrc_pkg::S1_TCH] = touch_irq & wkc_q[wrc_pkg::WK_TWD];
    wake = 1'b0;
    // (RULE_23) OR of enabled sources
    case (md_q)
      wrc_pkg::MD_SLEEP:
        wake = |(pin_irq & pin_irq_ie) | |({touch_irq, spi_irq, wkt_to, wdt_irq, bod_low} & per_irq_ie)
               | other_irq;
      wrc_pkg::MD_DSLEEP, wrc_pkg::MD_PDOWN:
        // (RULE_01) (RULE_02) double enable
        wake = |(pin_irq & pin_irq_ie & sle0_q) | |(per_src & per_irq_ie & sle1_q);
      wrc_pkg::MD_DPD:
        // (RULE_09) (RULE_11) deep powerdown sources
        wake = (!wakeup_pin_n & dpd_q[wrc_pkg::DC_WAKE])
               | (wkt_to & dpd_q[wrc_pkg::DC_LPO] & dpd_q[wrc_pkg::DC_LPD]);
      default:
        wake = 1'b0;
    endcase
  end

  // ----------------------------------------
  // register file, mode and wake timer
  // ----------------------------------------
  always_comb
  begin
    sle0_d = sle0_q;
    sle1_d = sle1_q;
    bodc_d = bodc_q;
    spc_d  = spc_q;
    wdm_d  = wdm_q;
    dpd_d  = dpd_q;
    pfe_d  = pfe_q;
    wkc_d  = wkc_q;
    clk_d  = clk_q;
    md_d   = md_q;
    wkn_d  = wkn_q;
    wkr_d  = wkr_q;
    wkt_to = 1'b0;
    rd_d   = 32'h0000_0000;
    // timer counts down while running
    if (wkr_q)
    begin
      // (RULE_11) stops in deep powerdown unless kept
      if ((md_q == wrc_pkg::MD_DPD) && !dpd_q[wrc_pkg::DC_LPD])
        wkr_d = 1'b0;
      else if (wkn_q <= WKT_W'(1))
      begin
        wkt_to = 1'b1;
        wkr_d  = 1'b0;
        wkn_d  = '0;
      end
      else
        wkn_d = wkn_q - WKT_W'(1);
    end
    // mode returns to run on wake
    if (wake)
      md_d = wrc_pkg::MD_RUN;
    // writes
    if (reg_wr)
    begin
      case (reg_addr)
        wrc_pkg::A_SLE0: sle0_d = reg_wdata[NPIN-1:0];
        wrc_pkg::A_SLE1: sle1_d = reg_wdata[wrc_pkg::S1_W-1:0];
        wrc_pkg::A_BODC: bodc_d = reg_wdata[3:0];
        wrc_pkg::A_SPC:  spc_d  = reg_wdata[1:0];
        wrc_pkg::A_WDM:  wdm_d  = reg_wdata[2:0];
        wrc_pkg::A_DPD:  dpd_d  = reg_wdata[3:0];
        wrc_pkg::A_PFE:  pfe_d  = reg_wdata[3:0];
        wrc_pkg::A_WKC:  wkc_d  = reg_wdata[1:0];
        wrc_pkg::A_CLK:  clk_d  = reg_wdata[1:0];
        wrc_pkg::A_WKN:
          // (RULE_06) start on count write
          if (dpd_q[wrc_pkg::DC_LPO] && wkc_q[wrc_pkg::WK_LPC])
          begin
            wkn_d = reg_wdata[WKT_W-1:0];
            wkr_d = 1'b1;
          end
        wrc_pkg::A_PMC:
          // mode entry; a pending wake wins
          if (!wake && (reg_wdata[2:0] <= 3'(wrc_pkg::MD_DPD)))
            md_d = wrc_pkg::wrc_mode_type'(reg_wdata[2:0]);
        default: ;
      endcase
    end
    // reads, data in the next cycle
    if (reg_rd)
    begin
      case (reg_addr)
        wrc_pkg::A_SLE0: rd_d[NPIN-1:0] = sle0_q;
        wrc_pkg::A_SLE1: rd_d[wrc_pkg::S1_W-1:0] = sle1_q;
        wrc_pkg::A_BODC: rd_d[3:0] = bodc_q;
        wrc_pkg::A_SPC:  rd_d[1:0] = spc_q;
        wrc_pkg::A_WDM:  rd_d[2:0] = wdm_q;
        wrc_pkg::A_DPD:  rd_d[3:0] = dpd_q;
        wrc_pkg::A_PFE:  rd_d[3:0] = pfe_q;
        wrc_pkg::A_WKC:  rd_d[1:0] = wkc_q;
        wrc_pkg::A_CLK:  rd_d[1:0] = clk_q;
        wrc_pkg::A_WKN:  rd_d[WKT_W-1:0] = wkn_q;
        wrc_pkg::A_PMC:  rd_d[2:0] = md_q;
        // (RULE_17) brownout status
        wrc_pkg::A_STAT: rd_d[6:0] = {bsc_q, prot_q, ext_clk_stable, wkr_q, wake_q, bod_low};
        default:         rd_d = 32'h0000_0000;
      endcase
    end
    wake_d = wake;
  end

  // register file registers
  always_ff @(posedge core_clk)
  begin
    if (soft_rst)
    begin
      sle0_d_reset();
    end
    else
    begin
      sle0_q <= sle0_d;
      sle1_q <= sle1_d;
      bodc_q <= bodc_d;
      spc_q  <= spc_d;
      wdm_q  <= wdm_d;
      dpd_q  <= dpd_d;
      pfe_q  <= pfe_d;
      wkc_q  <= wkc_d;
      clk_q  <= clk_d;
      md_q   <= md_d;
      wkn_q  <= wkn_d;
      wkr_q  <= wkr_d;
      rd_q   <= rd_d;
      wake_q <= wake_d;
    end
  end

  // default values of the register group
  task automatic sle0_d_reset();
    sle0_q <= '0;
    sle1_q <= '0;
    bodc_q <= wrc_pkg::BODC_RST;
    spc_q  <= 2'h0;
    wdm_q  <= 3'h0;
    dpd_q  <= 4'h0;
    pfe_q  <= wrc_pkg::PFE_RST;
    wkc_q  <= 2'h0;
    clk_q  <= 2'h0;
    md_q   <= wrc_pkg::MD_RUN;
    wkn_q  <= '0;
    wkr_q  <= 1'b0;
    rd_q   <= 32'h0000_0000;
    wake_q <= 1'b0;
  endtask

  // ----------------------------------------
  // debug and protection outputs
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      bsc_q <= 1'b0;
      dbg_q <= 1'b0;
    end
    else
    begin
      // (RULE_21) low selects scan; (RULE_22) tester drives it
      bsc_q <= !reset_pin_n;
      // (RULE_21) (RULE_19) debug off in reset, protected
      dbg_q <= reset_pin_n && (rs_d == wrc_pkg::RS_RUN) && (prot_d == wrc_pkg::PL_NONE);
    end
  end

  assign reg_rdata  = rd_q;
  assign wake_req   = wake_q;
  assign power_mode = md_q;
  assign chip_reset = (rs_q == wrc_pkg::RS_HOLD);
  assign osc_start  = strt_q;
  assign flash_init = strt_q;
  // (RULE_16) vector zero
  assign boot_addr  = wrc_pkg::BOOT_VEC;
  // (RULE_17) raw detector to controller
  assign bod_irq    = bod_low;
  // (RULE_13) oscillator default, switch only when stable
  assign ext_clk_en  = clk_q[wrc_pkg::CK_EN];
  assign ext_clk_sel = clk_q[wrc_pkg::CK_EN] & clk_q[wrc_pkg::CK_SEL] & ext_clk_stable;
  assign bscan_sel  = bsc_q;
  assign dbg_en     = dbg_q;
  // (RULE_19) programming by level
  assign isp_en         = (prot_q != wrc_pkg::PL_THR);
  assign isp_sector0_ok = (prot_q == wrc_pkg::PL_NONE);
  assign isp_full_only  = (prot_q == wrc_pkg::PL_TWO);
  // (RULE_20) always usable
  assign iap_en     = 1'b1;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_pin_rst;
    (!reset_pin_n && pfe_q[wrc_pkg::PF_RST] && md_q != wrc_pkg::MD_DPD) [*2] |=> chip_reset;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset missed"); // RULE_15

  property p_hold;
    $rose(chip_reset) |-> chip_reset [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("reset too short"); // RULE_14

  property p_dbg_rst;
    chip_reset |-> !dbg_en;
  endproperty
  a_dbg_rst: assert property (p_dbg_rst) else $error("debug on in reset"); // RULE_21

  property p_bscan;
    ##1 bscan_sel == !$past(reset_pin_n);
  endproperty
  a_bscan: assert property (p_bscan) else $error("scan select wrong"); // RULE_21

  property p_protect_level_three;
    prot_q == wrc_pkg::PL_THR |-> !isp_en && !dbg_en;
  endproperty
  a_protect_level_three: assert property (p_protect_level_three) else $error("level three leak"); // RULE_19

  property p_pin_wake;
    deep && ((pin_irq & pin_irq_ie & ~sle0_q) != '0) && ((pin_irq & sle0_q) == '0)
      && ((per_src & per_irq_ie & sle1_q) == '0) |=> !wake_req;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("unenabled pin woke"); // RULE_01

  property p_wkt;
    reg_wr && reg_addr == wrc_pkg::A_WKN && dpd_q[wrc_pkg::DC_LPO] && wkc_q[wrc_pkg::WK_LPC] && !chip_reset
      |=> wkr_q && wkn_q == $past(reg_wdata[WKT_W-1:0]);
  endproperty
  a_wkt: assert property (p_wkt) else $error("timer not started"); // RULE_06

  property p_dpd;
    md_q == wrc_pkg::MD_DPD && !dpd_q[wrc_pkg::DC_WAKE] && !wkr_q |=> !wake_req;
  endproperty
  a_dpd: assert property (p_dpd) else $error("wake pin not gated"); // RULE_09

  property p_clk;
    !ext_clk_stable |-> !ext_clk_sel;
  endproperty
  a_clk: assert property (p_clk) else $error("unstable source picked"); // RULE_13

  c_pin_rst: cover property (!reset_pin_n [*2] ##1 chip_reset);
  c_wake:    cover property (deep ##1 wake_req);
  c_wkt:     cover property (wkr_q ##1 !wkr_q);
  c_dpd:     cover property (md_q == wrc_pkg::MD_DPD ##1 md_q == wrc_pkg::MD_RUN);

endmodule
`default_nettype wire

// ==== inc/wrc_pkg.sv ====
// constants and types for the wake, reset and protection controller
`default_nettype none
package wrc_pkg;
  // register byte addresses
  localparam logic [5:0] A_SLE0 = 6'h00;
  localparam logic [5:0] A_SLE1 = 6'h04;
  localparam logic [5:0] A_BODC = 6'h08;
  localparam logic [5:0] A_SPC  = 6'h0C;
  localparam logic [5:0] A_WDM  = 6'h10;
  localparam logic [5:0] A_DPD  = 6'h14;
  localparam logic [5:0] A_PFE  = 6'h18;
  localparam logic [5:0] A_WKC  = 6'h1C;
  localparam logic [5:0] A_WKN  = 6'h20;
  localparam logic [5:0] A_PMC  = 6'h24;
  localparam logic [5:0] A_CLK  = 6'h28;
  localparam logic [5:0] A_STAT = 6'h2C;
  // start_logic_enable_one bits
  localparam int S1_BOD = 0;
  localparam int S1_WDT = 1;
  localparam int S1_WKT = 2;
  localparam int S1_SPI = 3;
  localparam int S1_TCH = 4;
  localparam int S1_W   = 5;
  // brownout_control fields
  localparam int BC_LVL = 0;
  localparam int BC_RST = 2;
  localparam int BC_INT = 3;
  // sleep_power_config, watchdog_mode_bits fields
  localparam int SP_BOD = 0;
  localparam int SP_WDO = 1;
  localparam int WM_EN  = 0;
  localparam int WM_INT = 1;
  localparam int WM_RST = 2;
  // deep_powerdown_control fields
  localparam int DC_WAKE = 0;
  localparam int DC_RST  = 1;
  localparam int DC_LPO  = 2;
  localparam int DC_LPD  = 3;
  // pin_function_enable, timer control, clock control fields
  localparam int PF_RST = 0;
  localparam int WK_LPC = 0;
  localparam int WK_TWD = 1;
  localparam int CK_EN  = 0;
  localparam int CK_SEL = 1;
  // reset values
  localparam logic [3:0] BODC_RST = 4'h0;
  localparam logic [3:0] PFE_RST  = 4'h1;
  localparam logic [31:0] BOOT_VEC = 32'h0000_0000;
  // power modes and reset states
  typedef enum logic [2:0] {MD_RUN, MD_SLEEP, MD_DSLEEP, MD_PDOWN, MD_DPD} wrc_mode_type;
  typedef enum logic {RS_HOLD, RS_RUN} wrc_rst_type;
  // protection levels
  localparam logic [1:0] PL_NONE = 2'h0;
  localparam logic [1:0] PL_ONE  = 2'h1;
  localparam logic [1:0] PL_TWO  = 2'h2;
  localparam logic [1:0] PL_THR  = 2'h3;
  // timing
  localparam int CLK_NS       = 25;
  localparam int RST_PULSE_NS = 50;
  localparam int RST_PIN_CYC  = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_HOLD_CYC = 8;
endpackage
`default_nettype wire

// ==== bench/wrc_board.sv ====
// board model: reset pin, wake pin, power-on and brownout detectors, scan tester
`timescale 1ns/100ps
`default_nettype none
module wrc_board #(
  parameter int SCAN_WAIT_CYC = 10000  // 250 us of 25 ns cycles
) (
  input  wire logic       core_clk,
  output logic            reset_pin_n,
  output logic            wakeup_pin_n,
  output logic            por_n,
  output logic [3:0]      bod_below
);
  int unsigned up_cyc;  // cycles since power-up

  // ----------------------------------------
  // pins idle high through board pull-ups
  // ----------------------------------------
  initial
  begin
    reset_pin_n  = 1'b1;
    wakeup_pin_n = 1'b1;
    por_n        = 1'b1;
    bod_below    = 4'h0;
    up_cyc       = 0;
  end

  // power-up time counter for the tester
  always @(posedge core_clk)
    up_cyc <= up_cyc + 1;

  // hold the reset pin low for a count of edges
  task automatic pull_reset(input int cyc);
    @(posedge core_clk);
    reset_pin_n <= 1'b0;
    repeat (cyc) @(posedge core_clk);
    reset_pin_n <= 1'b1;
  endtask

  // wake pin level, active low
  task automatic set_wake(input logic lvl_n);
    @(posedge core_clk);
    wakeup_pin_n <= lvl_n;
  endtask

  // supply below threshold flags
  task automatic set_bod(input logic [3:0] v);
    @(posedge core_clk);
    bod_below <= v;
  endtask

  // powered with pin high, long wait, then low
  task automatic scan_entry();
    while (up_cyc < SCAN_WAIT_CYC) @(posedge core_clk);
    reset_pin_n <= 1'b0;
  endtask

  task automatic scan_exit();
    @(posedge core_clk);
    reset_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== bench/wake_reset_control_tb_top.sv ====
// self-checking bench for the wake, reset and protection controller
`timescale 1ns/100ps
`default_nettype none
module wake_reset_control_tb_top;
  localparam int TIMEOUT_CYC = 20000;  // scan wait dominates the run
  logic        core_clk, reset, reg_wr, reg_rd, ext_clk_stable, spi_irq;
  logic        other_irq, wdt_irq, wdt_rst, wdt_fed, touch_irq;
  logic [5:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, boot_addr;
  logic [7:0]  pin_irq, pin_irq_ie;
  logic [4:0]  per_irq_ie;
  logic [3:0]  bod_below;
  logic [2:0]  power_mode;
  logic [1:0]  prot_pattern;
  logic        reset_pin_n, wakeup_pin_n, por_n, wake_req, chip_reset, osc_start, flash_init;
  logic        bod_irq, ext_clk_en, ext_clk_sel, bscan_sel, dbg_en, isp_en, isp_sector0_ok;
  logic        isp_full_only, iap_en;
  int          error_cnt, total_checks, cyc_cnt;

  // ----------------------------------------
  // design and board
  // ----------------------------------------
  wrc_top u_dut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reset_pin_n, .wakeup_pin_n, .por_n, .bod_below, .pin_irq, .pin_irq_ie, .per_irq_ie,
    .other_irq, .wdt_irq, .wdt_rst, .wdt_fed, .spi_irq, .touch_irq, .ext_clk_stable,
    .prot_pattern, .wake_req, .power_mode, .chip_reset, .osc_start, .flash_init, .boot_addr,
    .bod_irq, .ext_clk_en, .ext_clk_sel, .bscan_sel, .dbg_en, .isp_en, .isp_sector0_ok,
    .isp_full_only, .iap_en);
  wrc_board u_board (.core_clk, .reset_pin_n, .wakeup_pin_n, .por_n, .bod_below);

  // clock of 25 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // helper tasks
  // ----------------------------------------
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // settle point just after an edge
  task automatic steps(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // one-cycle register write
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read, data checked in the next cycle only
  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask

  // wait bounded for internal reset to end
  task automatic wait_rel();
    int n;
    n = 0;
    while (chip_reset !== 1'b0 && n < 40)
    begin
      steps(1);
      n++;
    end
    chk("chip_reset_release", 32'h0, {31'h0, chip_reset});
  endtask

  // bench reset with a chosen protection pattern
  task automatic do_reset(input logic [1:0] p);
    @(posedge core_clk);
    prot_pattern <= p;
    reset        <= 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    wait_rel();
  endtask

  // source k: 0 pin irq, 1 slave spi irq, 2 wake pin
  task automatic drive_src(input int k, input logic v);
    @(posedge core_clk);
    case (k)
      0: pin_irq[0] <= v;
      1: spi_irq <= v;
      default: u_board.set_wake(!v);
    endcase
  endtask

  // the one enable that was left out for source k
  task automatic add_en(input int k, input logic v);
    case (k)
      0: begin @(posedge core_clk); pin_irq_ie[0] <= v; end
      1: wr(wrc_pkg::A_SLE1, {28'h0, v, 3'h0});
      default: wr(wrc_pkg::A_DPD, {31'h0, v});
    endcase
  endtask

  // enter a mode, show no wake while unenabled, then wake once enabled
  task automatic wake_case(input logic [2:0] md, input int k);
    wr(wrc_pkg::A_PMC, {29'h0, md});
    steps(1);
    chk("mode_entered", {29'h0, md}, {29'h0, power_mode});
    drive_src(k, 1'b1);
    steps(4);
    chk("mode_kept", {29'h0, md}, {29'h0, power_mode});
    add_en(k, 1'b1);
    steps(1);
    chk("wake_req", 32'h1, {31'h0, wake_req});
    chk("mode_left", 32'h0, {29'h0, power_mode});
    drive_src(k, 1'b0);
    add_en(k, 1'b0);
  endtask

  // hang guard
  always @(posedge core_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == TIMEOUT_CYC)
    begin
      error_cnt++;
      close_out();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    int n;
    {reset, reg_wr, reg_rd, ext_clk_stable, spi_irq, other_irq} = 6'h20;
    {wdt_irq, wdt_rst, wdt_fed, touch_irq} = 4'h0;
    {reg_addr, reg_wdata, pin_irq, pin_irq_ie, per_irq_ie, prot_pattern} = '0;
    {error_cnt, total_checks, cyc_cnt} = '0;
    // protection levels, highest first, ending unlocked
    for (int p = 3; p >= 0; p--)
    begin
      do_reset(p[1:0]);
      chk("dbg_en", {31'h0, p == 0}, {31'h0, dbg_en});
      chk("isp_en", {31'h0, p != 3}, {31'h0, isp_en});
      chk("isp_full_only", {31'h0, p == 2}, {31'h0, isp_full_only});
      if (p < 2) chk("isp_sector0_ok", {31'h0, p == 0}, {31'h0, isp_sector0_ok});
      chk("iap_en", 32'h1, {31'h0, iap_en});
    end
    chk("boot_addr", wrc_pkg::BOOT_VEC, boot_addr);
    rd(wrc_pkg::A_PFE, {28'h0, wrc_pkg::PFE_RST}, "pin_function_enable");
    rd(wrc_pkg::A_BODC, {28'h0, wrc_pkg::BODC_RST}, "brownout_control");
    rd(6'h3C, 32'h0, "unmapped");
    // short pin pulse ignored, two-cycle pulse resets
    u_board.pull_reset(1);
    steps(3);
    chk("chip_reset_short", 32'h0, {31'h0, chip_reset});
    u_board.pull_reset(2);
    #1;
    n = 0;
    while (chip_reset !== 1'b1 && n < 3)
    begin
      steps(1);
      n++;
    end
    chk("osc_flash_rst", 32'h7, {29'h0, chip_reset, osc_start, flash_init});
    steps(2);
    chk("dbg_en_in_reset", 32'h0, {31'h0, dbg_en});
    wait_rel();
    // external clock selected only once stable
    wr(wrc_pkg::A_CLK, 32'h3);
    steps(1);
    chk("ext_clk_sel_unstable", 32'h2, {30'h0, ext_clk_en, ext_clk_sel});
    ext_clk_stable <= 1'b1;
    steps(1);
    chk("ext_clk_sel_stable", 32'h1, {31'h0, ext_clk_sel});
    ext_clk_stable <= 1'b0;
    // each brownout level selects its own detector bit
    for (int l = 0; l < 4; l++)
    begin
      wr(wrc_pkg::A_BODC, 32'h8 | l);
      u_board.set_bod(4'hF ^ (4'h1 << l));
      steps(2);
      chk("bod_irq_other", 32'h0, {31'h0, bod_irq});
      u_board.set_bod(4'h1 << l);
      steps(2);
      chk("bod_irq_sel", 32'h1, {31'h0, bod_irq});
    end
    rd(wrc_pkg::A_STAT, 32'h1, "status_bod");
    wr(wrc_pkg::A_BODC, 32'hF);
    steps(3);
    chk("bod_reset", 32'h1, {31'h0, chip_reset});
    u_board.set_bod(4'h0);
    wait_rel();
    // wake sources for sleep and deep modes, last enable applied late
    wr(wrc_pkg::A_SLE0, 32'h1);
    pin_irq_ie <= 8'h00;
    per_irq_ie <= 5'h0C;
    wake_case(3'h1, 0);
    wake_case(3'h3, 0);
    wake_case(3'h2, 1);
    wake_case(3'h4, 2);
    // wake timer from deep power-down, oscillator kept running
    wr(wrc_pkg::A_SLE1, 32'h4);
    wr(wrc_pkg::A_DPD, 32'hC);
    wr(wrc_pkg::A_WKC, 32'h1);
    wr(wrc_pkg::A_PMC, 32'h4);
    wr(wrc_pkg::A_WKN, 32'h6);
    steps(2);
    chk("timer_counting", 32'h4, {29'h0, power_mode});
    steps(6);
    chk("timer_wake", 32'h0, {29'h0, power_mode});
    // boundary scan entry with pin low, debug off
    u_board.scan_entry();
    steps(3);
    chk("scan_sel", 32'h2, {30'h0, bscan_sel, dbg_en});
    u_board.scan_exit();
    wait_rel();
    chk("debug_sel", 32'h1, {30'h0, bscan_sel, dbg_en});
    close_out();
  end
endmodule
`default_nettype wire
